// File: hw/rtcdt_trim.v
`timescale 1ns/1ps
`default_nettype none
`include "rtcdt_defs.vh"

module rtcdt_trim
(
   input  wire        i_core_clk,     // Core clock, 25 MHz
   input  wire        i_rst_n,        // Supply power-on reset, active low
   input  wire        i_osc_lvl,      // Crystal oscillator level, synchronous
   input  wire        i_minute_tick,  // One-cycle minute increment strobe
   input  wire        i_on_battery,   // High while running from backup supply
   input  wire        i_reg_wr,       // Register write strobe
   input  wire        i_reg_rd,       // Register read strobe
   input  wire [7:0]  i_reg_addr,     // Register address
   input  wire [7:0]  i_reg_wdata,    // Register write data
   output reg  [7:0]  o_reg_rdata,    // Register read data, valid after read
   output reg         o_clk_pin,      // Divided clock pin level
   output reg         o_clk_pin_oe    // Divided clock pin drive enable
);

   reg  [7:0]  trim_magnitude_value_q;
   reg         trim_sign_q;
   reg         pin_level_q;
   reg         square_wave_enable_q;
   reg         rate_select_top_q;
   reg         rate_select_mid_q;
   reg         rate_select_low_q;
   reg         osc_prev_q;
   reg         pend_q;
   reg         pend_d;
   reg  [16:0] cnt_q;
   reg  [16:0] cnt_d;
   reg  [16:0] len_q;
   reg  [16:0] half_q;
   reg  [16:0] nom;
   reg  [16:0] adj;
   reg  [16:0] len_d;
   reg         apply;
   reg         delay_only;
   reg         plus;
   reg         pin_d;
   reg  [7:0]  rdata_d;
   wire [1:0]  rate_lo;
   wire        osc_rise;
   wire        wrap;
   wire        reg_ok;

   assign rate_lo  = {rate_select_mid_q, rate_select_low_q};
   assign osc_rise = i_osc_lvl & ~osc_prev_q;
   assign wrap     = osc_rise & (cnt_q >= len_q - `RTCDT_CNT_ONE);
   // Host access is lost on the backup supply
   assign reg_ok   = ~i_on_battery;

   // Trim magnitude register
   always @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         trim_magnitude_value_q <= `RTCDT_TRIM_RST;
      end
      else if (i_reg_wr && reg_ok && i_reg_addr == `RTCDT_ADDR_TRIM)
      begin
         trim_magnitude_value_q <= i_reg_wdata;
      end
   end

   // Sign shares its byte with timekeeping bits held outside this block
   always @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         trim_sign_q <= 1'b0;
      end
      else if (i_reg_wr && reg_ok && i_reg_addr == `RTCDT_ADDR_SIGN)
      begin
         trim_sign_q <= i_reg_wdata[`RTCDT_SIGN_BIT];
      end
   end

   // Control register fields
   always @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         pin_level_q          <= 1'b0;
         square_wave_enable_q <= 1'b0;
         rate_select_top_q    <= 1'b0;
         rate_select_mid_q    <= 1'b0;
         rate_select_low_q    <= 1'b0;
      end
      else if (i_reg_wr && reg_ok && i_reg_addr == `RTCDT_ADDR_CTRL)
      begin
         pin_level_q          <= i_reg_wdata[`RTCDT_LEVEL_BIT];
         square_wave_enable_q <= i_reg_wdata[`RTCDT_ENABLE_BIT];
         rate_select_top_q    <= i_reg_wdata[`RTCDT_RS_TOP_BIT];
         rate_select_mid_q    <= i_reg_wdata[`RTCDT_RS_MID_BIT];
         rate_select_low_q    <= i_reg_wdata[`RTCDT_RS_LOW_BIT];
      end
   end

   // Read data
   always @*
   begin
      rdata_d = `RTCDT_BYTE_ZERO;
      case (i_reg_addr)
         `RTCDT_ADDR_TRIM:
         begin
            rdata_d = trim_magnitude_value_q;
         end
         `RTCDT_ADDR_SIGN:
         begin
            rdata_d[`RTCDT_SIGN_BIT] = trim_sign_q;
         end
         `RTCDT_ADDR_CTRL:
         begin
            rdata_d[`RTCDT_LEVEL_BIT]  = pin_level_q;
            rdata_d[`RTCDT_ENABLE_BIT] = square_wave_enable_q;
            rdata_d[`RTCDT_RS_TOP_BIT] = rate_select_top_q;
            rdata_d[`RTCDT_RS_MID_BIT] = rate_select_mid_q;
            rdata_d[`RTCDT_RS_LOW_BIT] = rate_select_low_q;
         end
         default:
         begin
            rdata_d = `RTCDT_BYTE_ZERO;
         end
      endcase
   end

   always @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_reg_rdata <= `RTCDT_BYTE_ZERO;
      end
      else if (i_reg_rd && reg_ok)
      begin
         o_reg_rdata <= rdata_d;
      end
   end

   // Length of the next output period
   always @*
   begin
      case (rate_lo)
         `RTCDT_RS_1HZ:
         begin
            nom = `RTCDT_PER_1HZ;
         end
         `RTCDT_RS_4K:
         begin
            nom = `RTCDT_PER_4K;
         end
         `RTCDT_RS_8K:
         begin
            nom = `RTCDT_PER_8K;
         end
         `RTCDT_RS_RAW:
         begin
            // Counter wraps every edge here; the pin bypasses it anyway
            nom = `RTCDT_PER_RAW;
         end
         default:
         begin
            nom = `RTCDT_PER_1HZ;
         end
      endcase
      if (rate_select_top_q)
      begin
         nom = `RTCDT_PER_1HZ;
      end
      // Two oscillator cycles per unit; zero gives no change
      adj        = {8'h00, trim_magnitude_value_q, 1'b0};
      // Top select corrects every period, else only the minute one
      apply      = rate_select_top_q | pend_q;
      // Fast rates with a small magnitude can only stretch
      delay_only = ~rate_select_top_q & (rate_lo != `RTCDT_RS_1HZ)
                   & ~trim_magnitude_value_q[`RTCDT_TRIM_MSB];
      plus       = ~trim_sign_q | delay_only;
      len_d      = nom;
      if (apply)
      begin
         if (plus)
         begin
            len_d = nom + adj;
         end
         else if (nom > adj + `RTCDT_PER_MIN)
         begin
            len_d = nom - adj;
         end
         else
         begin
            // Oversized removal at fast rates just clamps
            len_d = `RTCDT_PER_MIN;
         end
      end
   end

   always @*
   begin
      cnt_d = cnt_q;
      if (wrap)
      begin
         cnt_d = `RTCDT_CNT_RST;
      end
      else if (osc_rise)
      begin
         cnt_d = cnt_q + `RTCDT_CNT_ONE;
      end
      // A strobe landing on the consuming edge is kept for next time
      pend_d = i_minute_tick | (pend_q & ~wrap);
   end

   // A high oscillator level at release costs at most one stray count
   always @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         osc_prev_q <= 1'b0;
      end
      else
      begin
         osc_prev_q <= i_osc_lvl;
      end
   end

   always @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         pend_q <= 1'b0;
      end
      else
      begin
         pend_q <= pend_d;
      end
   end

   always @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         cnt_q <= `RTCDT_CNT_RST;
      end
      else
      begin
         cnt_q <= cnt_d;
      end
   end

   always @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         len_q  <= `RTCDT_PER_1HZ;
         half_q <= `RTCDT_CNT_RST;
      end
      else if (wrap)
      begin
         len_q  <= len_d;
         // High phase stays nominal; trim lands in the low phase
         half_q <= nom >> 1;
      end
   end

   // Pin level
   always @*
   begin
      if (i_on_battery)
      begin
         pin_d = 1'b0;
      end
      else if (!square_wave_enable_q)
      begin
         pin_d = pin_level_q;
      end
      else if (!rate_select_top_q && rate_lo == `RTCDT_RS_RAW)
      begin
         pin_d = i_osc_lvl;
      end
      else
      begin
         pin_d = (cnt_q < half_q);
      end
   end

   always @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_clk_pin <= 1'b0;
      end
      else
      begin
         o_clk_pin <= pin_d;
      end
   end

   // Pin floats only under power-on reset, also on the backup supply it drives low
   always @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_clk_pin_oe <= 1'b0;
      end
      else
      begin
         o_clk_pin_oe <= 1'b1;
      end
   end

endmodule // rtcdt_trim

`default_nettype wire

// File: hw/rtcdt_defs.vh
// Overview of operation
// - Volatile 8-bit trim magnitude register
// - Sign one removes cycles, zero inserts
// - Zero magnitude gives nominal periods
// - Each magnitude unit is two cycles
// - Minute-rate correction at minute increment
// - Pin drives signal only while enabled
// - No waveform while on backup battery
// - Low select bits pick output frequency
// - Periods 32768, 8, 4, 1 cycles
// - Code 11 passes raw oscillator
// - Code 00 corrected period 32768 plus/minus
// - Codes 01/10 delayed once per minute
// - Large magnitude at 01/10 need not track
// - Top select bit gives nominal 1 Hz
// - Top select bit corrects every period
// - Duty cycle need not stay 50%
// - Battery drives pin low, reset tristates
// - Unused output follows pin-level bit
`ifndef RTCDT_DEFS_VH
`define RTCDT_DEFS_VH

`define RTCDT_ADDR_SIGN   8'h03
`define RTCDT_ADDR_CTRL   8'h07
`define RTCDT_ADDR_TRIM   8'h09

`define RTCDT_SIGN_BIT    7
`define RTCDT_LEVEL_BIT   7
`define RTCDT_ENABLE_BIT  6
`define RTCDT_RS_TOP_BIT  2
`define RTCDT_RS_MID_BIT  1
`define RTCDT_RS_LOW_BIT  0
`define RTCDT_TRIM_MSB    7

`define RTCDT_RS_1HZ      2'h0
`define RTCDT_RS_4K       2'h1
`define RTCDT_RS_8K       2'h2
`define RTCDT_RS_RAW      2'h3

`define RTCDT_PER_1HZ     17'h08000
`define RTCDT_PER_4K      17'h00008
`define RTCDT_PER_8K      17'h00004
`define RTCDT_PER_MIN     17'h00002
`define RTCDT_PER_RAW     17'h00001
`define RTCDT_CNT_ONE     17'h00001

`define RTCDT_TRIM_RST    8'h00
`define RTCDT_CTRL_RST    8'h00
`define RTCDT_CNT_RST     17'h00000
`define RTCDT_BYTE_ZERO   8'h00

`endif

// File: dv/rtcdt_trim_sva.sv
`timescale 1ns/1ps
`default_nettype none
module rtcdt_trim_sva
(
   input wire logic       i_core_clk,   // clk
   input wire logic       i_rst_n,      // rst
   input wire logic       i_osc_lvl,    // osc
   input wire logic       i_on_battery, // bat
   input wire logic       i_reg_wr,     // wr
   input wire logic       i_reg_rd,     // rd
   input wire logic [7:0] i_reg_addr,   // addr
   input wire logic [7:0] i_reg_wdata,  // wdata
   input wire logic [7:0] o_reg_rdata,  // rdata
   input wire logic       o_clk_pin,    // pin
   input wire logic       o_clk_pin_oe  // oe
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   logic [7:0] ctl_q, trm_q;
   logic       sgn_q;
   wire        rd_ok = i_reg_rd && !i_on_battery;
   // Shadow of what the host wrote; battery writes are dropped as the device does
   always_ff @(posedge i_core_clk or negedge i_rst_n)
      if (!i_rst_n)
      begin
         ctl_q <= 8'h00;
         trm_q <= 8'h00;
         sgn_q <= 1'b0;
      end
      else if (i_reg_wr && !i_on_battery)
      begin
         if (i_reg_addr == 8'h07) ctl_q <= i_reg_wdata;
         if (i_reg_addr == 8'h09) trm_q <= i_reg_wdata;
         if (i_reg_addr == 8'h03) sgn_q <= i_reg_wdata[7];
      end
   chk_reset_tristate: assert property (disable iff (1'b0)
      !i_rst_n |-> !o_clk_pin_oe && !o_clk_pin) else $error("pin driven in reset");
   chk_drive_on: assert property ($past(i_rst_n) |-> o_clk_pin_oe)
      else $error("pin not driven");
   chk_battery_low: assert property (i_on_battery |=> !o_clk_pin)
      else $error("pin high on battery");
   chk_level_follow: assert property (!i_on_battery && !ctl_q[6] |=>
      o_clk_pin == $past(ctl_q[7])) else $error("pin not at level bit");
   chk_raw_follow: assert property (!i_on_battery && ctl_q[6] && ctl_q[2:0] == 3'h3
      |=> o_clk_pin == $past(i_osc_lvl)) else $error("raw clock wrong");
   chk_read_trim: assert property (rd_ok && i_reg_addr == 8'h09 |=>
      o_reg_rdata == $past(trm_q)) else $error("trim readback wrong");
   chk_read_sign: assert property (rd_ok && i_reg_addr == 8'h03 |=>
      o_reg_rdata == {$past(sgn_q), 7'h00}) else $error("sign readback wrong");
   chk_read_hold: assert property (!rd_ok |=> $stable(o_reg_rdata))
      else $error("read data moved");
endmodule // rtcdt_trim_sva
bind rtcdt_trim rtcdt_trim_sva u_sva (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
   .i_osc_lvl(i_osc_lvl), .i_on_battery(i_on_battery), .i_reg_wr(i_reg_wr),
   .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
   .o_reg_rdata(o_reg_rdata), .o_clk_pin(o_clk_pin), .o_clk_pin_oe(o_clk_pin_oe));
`default_nettype wire

// File: dv/rtcdt_osc_model.sv
`timescale 1ns/1ps
`default_nettype none
module rtcdt_osc_model
#(
   parameter int MIN_EDGES = 64 // Short stand-in for a minute
)
(
   input  wire logic i_core_clk,   // clk
   output var  logic o_osc_lvl,    // osc
   output var  logic o_minute_tick // minute
);
   int n = 0;
   initial o_osc_lvl = 1'b0;
   initial o_minute_tick = 1'b0;
   // Oscillator far faster than real so corrected periods fit the run
   always @(negedge i_core_clk)
   begin
      o_osc_lvl <= !o_osc_lvl;
      o_minute_tick <= !o_osc_lvl && n == MIN_EDGES - 1;
      n <= o_osc_lvl ? n : (n + 1) % MIN_EDGES;
   end
endmodule // rtcdt_osc_model
`default_nettype wire

// File: dv/rtcdt_trim_bench.sv
`timescale 1ns/1ps
`default_nettype none
module rtcdt_trim_bench;
   logic       clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, bat = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, d, m;
   wire        osc, tick, pin, oe;
   wire  [7:0] rdata;
   int         n_fail = 0, n_checks = 0, cyc = 0;
   always #20 clk = ~clk;
   rtcdt_osc_model u_osc (.i_core_clk(clk), .o_osc_lvl(osc), .o_minute_tick(tick));
   rtcdt_trim u_dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_osc_lvl(osc),
      .i_minute_tick(tick), .i_on_battery(bat), .i_reg_wr(wr), .i_reg_rd(rd),
      .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_clk_pin(pin),
      .o_clk_pin_oe(oe));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("MISMATCH %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
      @(negedge clk);
      {addr, wdata, wr} = {a, v, 1'b1};
      @(negedge clk);
      wr = 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a);
      @(negedge clk);
      {addr, rd} = {a, 1'b1};
      @(negedge clk);
      rd = 1'b0;
      d = rdata;
   endtask
   function automatic int nominal(input logic [2:0] r);
      return (r == 3'h1) ? 8 : 4;
   endfunction
   // Osc edges between pin rises, sampled at negedge; first two rises skipped as partial.
   // A tick seen during a period marks the period after the next rise as corrected.
   task automatic periods(input int nom, input int corr);
      int e, big, k;
      logic op, pp, td, tk, cor;
      {e, big, k} = {32'd0, 32'd0, -32'd2};
      {op, pp, td, tk, cor} = {osc, pin, tick, 1'b0, 1'b0};
      while (k < 24)
      begin
         @(negedge clk);
         if (osc && !op) e++;
         if (pin && !pp)
         begin
            if (k >= 0) chk(8'(e), 8'(cor ? nom + corr : nom));
            if (k >= 0 && e > nom) big++;
            cor = tk;
            tk = 1'b0;
            e = 0;
            k++;
         end
         tk = tk | td;
         {op, pp, td} = {osc, pin, tick};
      end
      chk(8'(big > 0), 8'(corr > 0));
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cyc++;
      // First period after reset is 32768 edges, about 65600 cycles
      if (cyc == 90000)
      begin
         n_fail++;
         results();
      end
   end
   initial
   begin
      d = 8'($urandom(32'hb103f4fc));
      repeat (5) @(negedge clk);
      chk(oe, 1'b0);
      rst_n = 1'b1;
      @(negedge clk);
      chk(oe, 1'b1);
      wr_reg(8'h07, 8'h80);
      @(negedge clk);
      chk(pin, 1'b1);
      for (int i = 0; i < 6; i++)
      begin
         m = (i == 0) ? 8'h00 : 8'(1 + $urandom % 20);
         wr_reg(8'h09, m);
         wr_reg(8'h03, {1'($urandom), 7'h00});
         wr_reg(8'h07, {5'h08, 3'(1 + i % 2)});
         rd_reg(8'h09);
         chk(d, m);
         periods(nominal(3'(1 + i % 2)), 2 * m);
      end
      wr_reg(8'h07, 8'h43);
      repeat (4) @(negedge clk);
      chk(pin, osc);
      bat = 1'b1;
      wr_reg(8'h09, ~m);
      chk(pin, 1'b0);
      bat = 1'b0;
      rd_reg(8'h09);
      chk(d, m);
      rd_reg(8'h20);
      chk(d, 8'h00);
      rst_n = 1'b0;
      #1 chk({oe, pin}, 2'b00);
      @(negedge clk);
      rst_n = 1'b1;
      rd_reg(8'h09);
      chk(d, 8'h00);
      results();
   end
endmodule // rtcdt_trim_bench
`default_nettype wire
